// ---- rtl/timer24_capture_compare.sv ----
// dual 24-bit timer: capture/compare unit of the first timer and the
// full second timer with dividers, registers over AXI4-Lite
// assumes pins are asynchronous; bus is idle while ce is low
//
// Summary of operation
// - capture mode: edge loads count, raises irq
// - software write beats simultaneous capture
// - capture edge follows rise/fall selects
// - no first-timer capture while disabled
// - compare equal raises irq and match signal
// - matches 0/1 set/reset A, 2/3 B
// - match 3 also starts the A/D
// - first match one cycle after increment
// - output pin levels set by control register
// - second counts while enabled; counter-word writes are ignored
// - disabling second timer clears it at once
// - clock select: direct, divide 2..256, event
// - event edge follows fifth edge selects
// - overflow sets sticky flag and irq
// - one-shot stop holds zero until restart
// - re-writing enable while counting is harmless
// - soft clear-start restarts from zero if enabled
// - capture 0 direct, 1-3 divided, irq each
// - divider ratios from controls, source select
// - compare 0 triggers real-time port, 1 irq only
// - second match one cycle after increment
// - first counts up on selected clock when enabled
`timescale 1ns/10ps
module timer24_capture_compare (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic [3:0] first_capture_in,
   input wire logic [3:0] second_capture_in,
   input wire logic first_event_input,
   input wire logic second_event_input,
   output logic output_pin_a,
   output logic output_pin_b,
   output logic [3:0] first_capture_input_irq,
   output logic [3:0] first_compare_irq,
   output logic [3:0] second_capture_input_irq,
   output logic [1:0] second_compare_irq,
   output logic second_overflow_irq,
   output logic ad_start_trigger,
   output logic rto_trigger
);
   import timer24_pkg::*;

   typedef struct packed {
      logic [9:0] s1;
      logic [9:0] s2;
      logic [9:0] s3;
      logic [7:0] presc;
      logic [7:0] first_timer_cc_mode_ctrl;
      logic [7:0] second_timer_mode_ctrl;
      logic [15:0] edge_sel_b;
      logic [15:0] edge_sel_c;
      logic [3:0] timer_output_ctrl;
      logic second_overflow_flag;
      logic [2:0][6:0] divider_ctrl;
      logic [2:0][6:0] div_cnt;
      logic divider_source_select;
      logic [23:0] first_timer_counter;
      logic [23:0] second_timer_counter;
      logic inc1;
      logic inc2;
      logic stop2;
      logic [3:0][23:0] first_capcomp;
      logic [3:0][23:0] second_capture;
      logic [1:0][23:0] second_compare;
      logic lvl_a;
      logic lvl_b;
      logic pin_a;
      logic pin_b;
      logic [3:0] cap1_irq;
      logic [3:0] cmp1_irq;
      logic [3:0] cap2_irq;
      logic [1:0] cmp2_irq;
      logic ovf_irq;
      logic ad_trig;
      logic rto_trig;
      logic awrdy;
      logic wrdy;
      logic arrdy;
      logic [7:0] waddr;
      logic [31:0] wdat;
      logic [3:0] wstb;
      logic bvld;
      logic [1:0] bres;
      logic rvld;
      logic [31:0] rdat;
      logic [1:0] rres;
   } state_t;

   localparam state_t RST = '{awrdy: 1'b1, wrdy: 1'b1, arrdy: 1'b1,
                              default: '0};

   state_t st_r;
   state_t st_nxt;
   logic [9:0] rsel;
   logic [9:0] fsel;
   logic [9:0] edg;
   logic wr_do;
   logic [5:0] widx;
   logic [31:0] wmask;
   logic [31:0] wv;
   logic [32:0] rv;
   logic [32:0] rrv;
   logic cs_wr;
   logic en_wr;
   logic ovf_wr;
   logic ovf_set;
   logic [3:0] cc_wr;
   logic [2:0] dv_wr;
   logic [3:0] m1;
   logic [1:0] m2;
   logic [2:0] dfire;
   logic [3:0] trig2;
   logic en1;
   logic capm;
   logic tick1;
   logic tick2;
   logic src;
   logic [7:0] lim;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // low k prescaler bits all ones gives one tick per 2**k cycles
   function automatic logic tick_of(input logic [3:0] code,
                                    input logic [7:0] p,
                                    input logic ev);
      logic t;
      t = 1'b1;
      for (int i = 0; i < 8; i++) begin
         if (i < int'(code)) t = t & p[i];
      end
      if (code == CLK_EXT) t = ev;
      else if (code > CLK_DIV_LAST) t = 1'b0;
      return t;
   endfunction : tick_of

   // bit 32 flags a mapped word
   function automatic logic [32:0] rd_reg(input state_t s,
                                          input logic [5:0] w);
      logic [32:0] v;
      v = '0;
      case (w)
         A_MODE1[7:2]: v = {1'b1, 24'h000000, s.first_timer_cc_mode_ctrl};
         A_MODE2[7:2]: v = {1'b1, 24'h000000, s.second_timer_mode_ctrl};
         A_EDGE_B[7:2]: v = {1'b1, 16'h0000, s.edge_sel_b};
         A_EDGE_C[7:2]: v = {1'b1, 16'h0000, s.edge_sel_c};
         A_TOC[7:2]: v = {1'b1, 28'h0000000, s.timer_output_ctrl};
         A_OVF[7:2]: v = {1'b1, 31'h00000000, s.second_overflow_flag};
         A_ESEL[7:2]: v = {1'b1, 31'h00000000, s.divider_source_select};
         A_CNT1[7:2]: v = {1'b1, 8'h00, s.first_timer_counter};
         A_CNT2[7:2]: v = {1'b1, 8'h00, s.second_timer_counter};
         default: v = '0;
      endcase
      for (int i = 0; i < 4; i++) begin
         if (w == 6'(A_CC0[7:2] + i)) v = {1'b1, 8'h00, s.first_capcomp[i]};
         if (w == 6'(A_CP0[7:2] + i)) v = {1'b1, 8'h00, s.second_capture[i]};
      end
      for (int i = 0; i < 3; i++) begin
         if (w == 6'(A_DVC0[7:2] + i)) v = {1'b1, 25'h0000000, s.divider_ctrl[i]};
      end
      for (int i = 0; i < 2; i++) begin
         if (w == 6'(A_CM0[7:2] + i)) v = {1'b1, 8'h00, s.second_compare[i]};
      end
      return v;
   endfunction : rd_reg

   always_comb begin
      st_nxt = st_r;
      // ---------------------------------------------------------------
      // pin synchronisers and edge selection
      // ---------------------------------------------------------------
      st_nxt.s1 = {second_event_input, first_event_input,
                   second_capture_in, first_capture_in};
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      rsel = {st_r.edge_sel_c[EV_IDX], st_r.edge_sel_b[EV_IDX],
              st_r.edge_sel_c[3:0], st_r.edge_sel_b[3:0]};
      fsel = {st_r.edge_sel_c[FALL_LSB+EV_IDX],
              st_r.edge_sel_b[FALL_LSB+EV_IDX],
              st_r.edge_sel_c[FALL_LSB+:4], st_r.edge_sel_b[FALL_LSB+:4]};
      edg = (st_r.s2 & ~st_r.s3 & rsel) | (~st_r.s2 & st_r.s3 & fsel);
      st_nxt.presc = st_r.presc + 8'h01;

      // ---------------------------------------------------------------
      // AXI4-Lite slave
      // ---------------------------------------------------------------
      if (awvalid && st_r.awrdy) begin
         st_nxt.waddr = awaddr;
         st_nxt.awrdy = 1'b0;
      end
      if (wvalid && st_r.wrdy) begin
         st_nxt.wdat = wdata;
         st_nxt.wstb = wstrb;
         st_nxt.wrdy = 1'b0;
      end
      wr_do = !st_r.awrdy && !st_r.wrdy && !st_r.bvld;
      widx = st_r.waddr[7:2];
      for (int b = 0; b < 4; b++) wmask[b*8+:8] = {8{st_r.wstb[b]}};
      rv = rd_reg(st_r, widx);
      wv = (rv[31:0] & ~wmask) | (st_r.wdat & wmask);
      cs_wr = 1'b0;
      en_wr = 1'b0;
      ovf_wr = 1'b0;
      if (wr_do) begin
         st_nxt.bvld = 1'b1;
         st_nxt.bres = rv[32] ? RESP_OKAY : RESP_SLVERR;
         case (widx)
            A_MODE1[7:2]: st_nxt.first_timer_cc_mode_ctrl = wv[7:0];
            A_MODE2[7:2]: begin
               // clear-start is an action bit and always reads zero
               st_nxt.second_timer_mode_ctrl = wv[7:0];
               st_nxt.second_timer_mode_ctrl[CS_B] = 1'b0;
               cs_wr = wv[CS_B];
               en_wr = wv[EN_B];
            end
            A_EDGE_B[7:2]: st_nxt.edge_sel_b = wv[15:0];
            A_EDGE_C[7:2]: st_nxt.edge_sel_c = wv[15:0];
            A_TOC[7:2]: st_nxt.timer_output_ctrl = wv[3:0];
            A_OVF[7:2]: ovf_wr = 1'b1;
            A_ESEL[7:2]: st_nxt.divider_source_select = wv[0];
            default: ;
         endcase
      end
      for (int i = 0; i < 4; i++) begin
         cc_wr[i] = wr_do && widx == 6'(A_CC0[7:2] + i);
      end
      for (int i = 0; i < 2; i++) begin
         if (wr_do && widx == 6'(A_CM0[7:2] + i))
            st_nxt.second_compare[i] = wv[23:0];
      end
      if (st_r.bvld && bready) begin
         st_nxt.bvld = 1'b0;
         st_nxt.awrdy = 1'b1;
         st_nxt.wrdy = 1'b1;
      end
      rrv = rd_reg(st_r, araddr[7:2]);
      if (arvalid && st_r.arrdy) begin
         st_nxt.rdat = rrv[31:0];
         st_nxt.rres = rrv[32] ? RESP_OKAY : RESP_SLVERR;
         st_nxt.rvld = 1'b1;
         st_nxt.arrdy = 1'b0;
      end
      if (st_r.rvld && rready) begin
         st_nxt.rvld = 1'b0;
         st_nxt.arrdy = 1'b1;
      end

      // ---------------------------------------------------------------
      // first timer: count, capture, compare, outputs
      // ---------------------------------------------------------------
      en1 = st_r.first_timer_cc_mode_ctrl[EN_B];
      capm = st_r.first_timer_cc_mode_ctrl[CAPM_B];
      tick1 = tick_of(st_r.first_timer_cc_mode_ctrl[CLK_LSB+:4],
                      st_r.presc, edg[8]);
      st_nxt.inc1 = 1'b0;
      if (!en1) begin
         st_nxt.first_timer_counter = '0;
      end else if (tick1) begin
         st_nxt.first_timer_counter = st_r.first_timer_counter + 24'h000001;
         st_nxt.inc1 = 1'b1;
      end
      st_nxt.cap1_irq = '0;
      for (int i = 0; i < 4; i++) begin
         // a bus write to the same register discards the capture
         if (cc_wr[i]) begin
            st_nxt.first_capcomp[i] = wv[23:0];
         end else if (capm && en1 && edg[i]) begin
            st_nxt.first_capcomp[i] = st_r.first_timer_counter;
            st_nxt.cap1_irq[i] = 1'b1;
         end
         // match only on the cycle after an increment
         m1[i] = !capm && st_r.inc1 &&
                 st_r.first_timer_counter == st_r.first_capcomp[i];
      end
      st_nxt.cmp1_irq = m1;
      st_nxt.ad_trig = m1[3];
      // reset wins when set and reset match together
      if (m1[1]) st_nxt.lvl_a = 1'b0;
      else if (m1[0]) st_nxt.lvl_a = 1'b1;
      if (m1[3]) st_nxt.lvl_b = 1'b0;
      else if (m1[2]) st_nxt.lvl_b = 1'b1;
      st_nxt.pin_a = (st_nxt.lvl_a & st_nxt.timer_output_ctrl[A_EN_B]) ^
                     st_nxt.timer_output_ctrl[A_INV_B];
      st_nxt.pin_b = (st_nxt.lvl_b & st_nxt.timer_output_ctrl[B_EN_B]) ^
                     st_nxt.timer_output_ctrl[B_INV_B];

      // ---------------------------------------------------------------
      // second timer: count, overflow, one-shot, clear-start
      // ---------------------------------------------------------------
      // clock select is sampled live, so changing it mid-count glitches;
      // the written code applies at once, like the enable written with it
      tick2 = tick_of(st_nxt.second_timer_mode_ctrl[CLK_LSB+:4],
                      st_r.presc, edg[9]);
      st_nxt.inc2 = 1'b0;
      ovf_set = 1'b0;
      if (!st_nxt.second_timer_mode_ctrl[EN_B]) begin
         st_nxt.second_timer_counter = '0;
         st_nxt.stop2 = 1'b0;
      end else if (cs_wr) begin
         st_nxt.second_timer_counter = '0;
         st_nxt.stop2 = 1'b0;
      end else if (st_r.stop2) begin
         if (en_wr) st_nxt.stop2 = 1'b0;
      end else if (tick2) begin
         // bus writes to the counter word are ignored
         st_nxt.second_timer_counter = st_r.second_timer_counter + 24'h000001;
         st_nxt.inc2 = 1'b1;
         if (st_r.second_timer_counter == CNT_MAX) begin
            ovf_set = 1'b1;
            st_nxt.stop2 = st_r.second_timer_mode_ctrl[OST_B];
         end
      end
      // set wins over a simultaneous software clear
      st_nxt.second_overflow_flag = ovf_set |
         (ovf_wr ? wv[0] : st_r.second_overflow_flag);
      st_nxt.ovf_irq = ovf_set;

      // ---------------------------------------------------------------
      // event dividers and second-timer captures and compares
      // ---------------------------------------------------------------
      for (int i = 0; i < 3; i++) begin
         dv_wr[i] = wr_do && widx == 6'(A_DVC0[7:2] + i);
         if (dv_wr[i]) st_nxt.divider_ctrl[i] =
            wv[6:0] & (i == 2 ? DVC_MASK_HI : DVC_MASK_LO);
         lim = {1'b0, st_r.divider_ctrl[i]};
         if (st_r.divider_ctrl[i] == 7'h00)
            lim = (i == 2) ? DV_FULL_HI : DV_FULL_LO;
         src = (i == 2 && st_r.divider_source_select) ? dfire[1]
                                                      : edg[5+i];
         dfire[i] = 1'b0;
         if (dv_wr[i]) begin
            st_nxt.div_cnt[i] = '0;
         end else if (src) begin
            if ({1'b0, st_r.div_cnt[i]} + 8'h01 == lim) begin
               st_nxt.div_cnt[i] = '0;
               dfire[i] = 1'b1;
            end else begin
               st_nxt.div_cnt[i] = st_r.div_cnt[i] + 7'h01;
            end
         end
      end
      trig2 = {dfire, edg[4]};
      for (int i = 0; i < 4; i++) begin
         if (trig2[i])
            st_nxt.second_capture[i] = st_r.second_timer_counter;
      end
      st_nxt.cap2_irq = trig2;
      for (int i = 0; i < 2; i++) begin
         m2[i] = st_r.inc2 &&
                 st_r.second_timer_counter == st_r.second_compare[i];
      end
      st_nxt.cmp2_irq = m2;
      st_nxt.rto_trig = m2[0];
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) st_r <= RST;
      else if (ce) st_r <= st_nxt;
   end

   assign awready = st_r.awrdy;
   assign wready = st_r.wrdy;
   assign bvalid = st_r.bvld;
   assign bresp = st_r.bres;
   assign arready = st_r.arrdy;
   assign rvalid = st_r.rvld;
   assign rdata = st_r.rdat;
   assign rresp = st_r.rres;
   assign output_pin_a = st_r.pin_a;
   assign output_pin_b = st_r.pin_b;
   assign first_capture_input_irq = st_r.cap1_irq;
   assign first_compare_irq = st_r.cmp1_irq;
   assign second_capture_input_irq = st_r.cap2_irq;
   assign second_compare_irq = st_r.cmp2_irq;
   assign second_overflow_irq = st_r.ovf_irq;
   assign ad_start_trigger = st_r.ad_trig;
   assign rto_trigger = st_r.rto_trig;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   cap_load_a: assert property (ce && capm && en1 && edg[0] && !cc_wr[0]
      |=> first_capture_input_irq[0] &&
          st_r.first_capcomp[0] == $past(st_r.first_timer_counter))
      else $error("capture 0 did not load the count");
   cap_write_wins_a: assert property (ce && cc_wr[0] && edg[0]
      |=> !first_capture_input_irq[0] &&
          st_r.first_capcomp[0] == $past(wv[23:0]))
      else $error("capture beat a register write");
   cap_idle_a: assert property (ce && !en1
      |=> first_capture_input_irq == 4'h0)
      else $error("capture while first timer disabled");
   cmp_ad_a: assert property (ce && !capm && st_r.inc1 &&
      st_r.first_timer_counter == st_r.first_capcomp[3]
      |=> first_compare_irq[3] && ad_start_trigger ##1 !output_pin_b ||
          st_r.timer_output_ctrl[B_INV_B])
      else $error("match 3 missed irq or A/D start");
   out_set_a: assert property (ce && m1[0] && !m1[1]
      |=> st_r.lvl_a)
      else $error("output A not set by match 0");
   stop_clear_a: assert property (ce && !st_nxt.second_timer_mode_ctrl[EN_B]
      |=> st_r.second_timer_counter == 24'h000000 && !st_r.stop2)
      else $error("second timer not cleared on disable");
   ovf_flag_a: assert property (ce && ovf_set
      |=> second_overflow_irq && st_r.second_overflow_flag &&
          st_r.second_timer_counter == 24'h000000)
      else $error("overflow flag or irq missing");
   oneshot_hold_a: assert property (ce && st_r.stop2 && !en_wr && !cs_wr
      |=> st_r.second_timer_counter == 24'h000000 &&
          (st_r.stop2 || !st_r.second_timer_mode_ctrl[EN_B]))
      else $error("one-shot stop did not hold zero");
   count_up_a: assert property (ce && st_nxt.inc2 &&
      st_r.second_timer_counter != CNT_MAX
      |=> st_r.second_timer_counter ==
          $past(st_r.second_timer_counter) + 24'h000001)
      else $error("second timer failed to count up");
   rto_trig_a: assert property (ce && st_r.inc2 &&
      st_r.second_timer_counter == st_r.second_compare[0]
      |=> rto_trigger && second_compare_irq[0])
      else $error("compare 0 missed real-time trigger");
endmodule : timer24_capture_compare

// ---- rtl/timer24_pkg.sv ----
// constants for the dual 24-bit capture/compare timer block
// assumes a 32-bit AXI4-Lite slave port with an 8-bit byte address
package timer24_pkg;
   localparam logic [23:0] CNT_MAX = 24'hFFFFFF;
   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] A_MODE1 = 8'h00;
   localparam logic [7:0] A_MODE2 = 8'h04;
   localparam logic [7:0] A_EDGE_B = 8'h08;
   localparam logic [7:0] A_EDGE_C = 8'h0C;
   localparam logic [7:0] A_TOC = 8'h10;
   localparam logic [7:0] A_OVF = 8'h14;
   localparam logic [7:0] A_DVC0 = 8'h18;
   localparam logic [7:0] A_ESEL = 8'h24;
   localparam logic [7:0] A_CNT1 = 8'h28;
   localparam logic [7:0] A_CNT2 = 8'h2C;
   localparam logic [7:0] A_CC0 = 8'h30;
   localparam logic [7:0] A_CP0 = 8'h40;
   localparam logic [7:0] A_CM0 = 8'h50;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int EN_B = 0;
   localparam int CAPM_B = 1;
   localparam int CS_B = 1;
   localparam int OST_B = 2;
   localparam int CLK_LSB = 4;
   localparam int FALL_LSB = 8;
   localparam int EV_IDX = 4;
   localparam int A_EN_B = 0;
   localparam int A_INV_B = 1;
   localparam int B_EN_B = 2;
   localparam int B_INV_B = 3;
   // ----------------------------------------------------------------
   // clock select codes, divider limits, bus responses
   // ----------------------------------------------------------------
   localparam logic [3:0] CLK_DIV_LAST = 4'h8;
   localparam logic [3:0] CLK_EXT = 4'hF;
   localparam logic [7:0] DV_FULL_LO = 8'h40;
   localparam logic [7:0] DV_FULL_HI = 8'h80;
   localparam logic [6:0] DVC_MASK_LO = 7'h3F;
   localparam logic [6:0] DVC_MASK_HI = 7'h7F;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : timer24_pkg

// ---- verif/testbench.sv ----
// self-checking bench for the dual 24-bit capture/compare timer
// assumes AXI4-Lite register map and pulse timing of timer24_pkg
`timescale 1ns/10ps
module testbench;
   import timer24_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic ce = 1'b1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   // bready and rready stay high: every answer is taken when it comes
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1;
   logic arvalid = 1'b0, rready = 1'b1;
   logic [31:0] wdata = 32'h0, rdata, rnd;
   logic [3:0] wstrb = 4'h0, fpins, spins, fcap, fcmp, scap;
   logic awready, wready, bvalid, arready, rvalid;
   logic fev, sev, pin_a, pin_b, sovf, ad_trig, rto;
   logic [1:0] bresp, rresp, scmp;
   logic [16:0] pulses;
   logic [9:0] pins_lv = 10'h000;
   logic [33:0] expect_q[$];
   logic [31:0] ev_sel[3] = '{32'h10, 32'h1000, 32'h1010};
   int ev_n[3] = '{3, 3, 6};
   int cc_val[4] = '{10, 40, 20, 60};
   int n_mismatch = 0, n_checks = 0, cycles = 0, seed = 81227, j;
   assign pulses = {rto, ad_trig, sovf, scmp, scap, fcmp, fcap};
   always #12.5 aclk = ~aclk;
   timer24_capture_compare u_timer24_capture_compare (
      .aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .first_capture_in(fpins), .second_capture_in(spins),
      .first_event_input(fev), .second_event_input(sev),
      .output_pin_a(pin_a), .output_pin_b(pin_b),
      .first_capture_input_irq(fcap), .first_compare_irq(fcmp),
      .second_capture_input_irq(scap), .second_compare_irq(scmp),
      .second_overflow_irq(sovf), .ad_start_trigger(ad_trig),
      .rto_trigger(rto));
   trigger_source u_trigger_source (.aclk(aclk), .first_pins(fpins),
      .second_pins(spins), .first_event(fev), .second_event(sev));
   task automatic chk(input string nm, input logic [33:0] s, e);
      n_checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : print_verdict
   // address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er = RESP_OKAY);
      logic ta, tw;
      ta = 1'b0;
      tw = 1'b0;
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(ta && tw)) begin
         @(posedge aclk);
         ta = ta | awready;
         tw = tw | wready;
         awvalid <= ~ta;
         wvalid <= ~tw;
      end
      do @(posedge aclk); while (!bvalid);
      chk("bresp", bresp, er);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [33:0] e);
      expect_q.push_back(e);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge aclk); while (!rvalid);
   endtask : rd
   task automatic wait_pulse(input int k);
      int i;
      for (i = 0; i < 3000 && pulses[k] !== 1'b1; i++) @(posedge aclk);
      chk("pulse", pulses[k], 1'b1);
   endtask : wait_pulse
   task automatic quiet(input int n, input int k);
      int hits;
      hits = 0;
      repeat (n) begin
         @(posedge aclk);
         hits += pulses[k];
      end
      chk("quiet", hits, 0);
   endtask : quiet
   task automatic pin(input int b, input logic v);
      pins_lv[b] = v;
      u_trigger_source.drive(pins_lv, 1);
   endtask : pin
   // -----------------------------------------------------------------
   // read-data monitor and hang guard
   // -----------------------------------------------------------------
   always @(posedge aclk) begin
      cycles++;
      if (rvalid && rready)
         chk("rdata", {rresp, rdata}, expect_q.pop_front());
      if (cycles == 20000) begin
         n_mismatch++;
         print_verdict();
      end
   end
   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(A_MODE2, 34'h0);
      rd(8'h5C, {RESP_SLVERR, 32'h0});
      wr(8'h5C, 32'hFFFFFFFF, RESP_SLVERR);
      rnd = $random(seed);
      wr(A_CM0 + 8'h04, rnd);
      rd(A_CM0 + 8'h04, {RESP_OKAY, 8'h00, rnd[23:0]});
      // second timer compare, soft restart, disable
      wr(A_CM0, 32'h10);
      wr(A_CM0 + 8'h04, 32'h28);
      wr(A_MODE2, 32'h1);
      wait_pulse(16);
      chk("scmp", scmp, 2'b01);
      wait_pulse(13);
      chk("rto", rto, 1'b0);
      wr(A_MODE2, 32'h3);
      wait_pulse(16);
      wr(A_EDGE_C, 32'h1);
      pin(4, 1'b1);
      wait_pulse(8);
      wr(A_MODE2, 32'h0);
      rd(A_CNT2, 34'h0);
      // event clock, every edge choice; clock changed only while stopped
      for (j = 0; j < 3; j++) begin
         wr(A_MODE2, 32'h0);
         wr(A_EDGE_C, ev_sel[j]);
         wr(A_MODE2, 32'hF1);
         repeat (3) begin
            pin(9, 1'b1);
            pin(9, 1'b0);
         end
         wr(A_CNT2, 32'h0);
         rd(A_CNT2, {RESP_OKAY, 32'(ev_n[j])});
      end
      // divider 0 fires on every second rise of capture input 1
      wr(A_EDGE_C, 32'h2);
      wr(A_DVC0, 32'h2);
      pin(5, 1'b1);
      pin(5, 1'b0);
      quiet(4, 9);
      pin(5, 1'b1);
      wait_pulse(9);
      quiet(4, 14);
      // first timer capture gating and edge choice
      wr(A_EDGE_B, 32'h1);
      wr(A_MODE1, 32'h2);
      wr(A_CC0, 32'h123);
      pin(0, 1'b1);
      quiet(8, 0);
      rd(A_CC0, {RESP_OKAY, 32'h123});
      wr(A_MODE1, 32'h3);
      pin(0, 1'b0);
      quiet(8, 0);
      pin(0, 1'b1);
      wait_pulse(0);
      // first timer compare outputs
      wr(A_MODE1, 32'h0);
      for (j = 0; j < 4; j++) wr(A_CC0 + 8'(4 * j), 32'(cc_val[j]));
      wr(A_TOC, 32'h5);
      wr(A_MODE1, 32'h1);
      wait_pulse(4);
      wait_pulse(6);
      chk("pin_a", pin_a, 1'b1);
      wait_pulse(5);
      chk("pin_b", pin_b, 1'b1);
      wait_pulse(7);
      chk("ad_trig", ad_trig, 1'b1);
      chk("pin_a", pin_a, 1'b0);
      chk("pin_b", pin_b, 1'b0);
      wr(A_TOC, 32'hF);
      repeat (2) @(posedge aclk);
      chk("pins", {pin_a, pin_b}, 2'b11);
      print_verdict();
   end
endmodule : testbench

// ---- verif/trigger_source.sv ----
// far-side model: capture trigger pins and event pins of both timers
// assumes one bench process calls drive at a time, right after an edge
`timescale 1ns/10ps
module trigger_source (
   input wire logic aclk,
   output logic [3:0] first_pins,
   output logic [3:0] second_pins,
   output logic first_event,
   output logic second_event
);
   // levels move just after an edge and stand for hold cycles; the next
   // call waits one more edge, so a level stands two cycles at least
   task automatic drive(input logic [9:0] lv, input int hold);
      @(posedge aclk);
      {second_event, first_event, second_pins, first_pins} <= lv;
      repeat (hold) @(posedge aclk);
   endtask : drive
   initial begin
      {second_event, first_event, second_pins, first_pins} = 10'h000;
   end
endmodule : trigger_source
